// ---- design/fecth_pkg.sv ----
// Shared constants, types and state codes of the codec test harness.
`default_nettype none

package fecth_pkg;

	// Data path geometry.
	localparam int unsigned WORD_W   = 66;
	localparam int unsigned CW_WORDS = 32;
	localparam int unsigned CTR_W    = 32;
	localparam int unsigned CODE_W   = 8;
	localparam int unsigned TMR_W    = 32;
	localparam int unsigned WCNT_W   = 5;

	// Sync header of a data block, bit 0 leaving first.
	localparam logic [1:0] SYNC_DATA = 2'h2;

	// One flipped bit is a burst the decoder can repair; two bits 40
	// apart exceed its burst reach and cannot be repaired.
	localparam logic [WORD_W-1:0] CORR_MASK   = 66'h1;
	localparam logic [WORD_W-1:0] UNCORR_MASK = 66'h100_0000_0001;

	// Checker lock and self-test wait limits, in words or cycles.
	localparam logic [3:0]       CHK_LOCK_RUN = 4'h8;
	localparam logic [TMR_W-1:0] LOCK_LIMIT   = 32'h0000_0800;

	// Self-test result codes.
	localparam logic [CODE_W-1:0] CODE_OK      = 8'h00;
	localparam logic [CODE_W-1:0] CODE_ALIGN   = 8'h01;
	localparam logic [CODE_W-1:0] CODE_LOCK    = 8'h02;
	localparam logic [CODE_W-1:0] CODE_DATA    = 8'h03;
	localparam logic [CODE_W-1:0] CODE_UNCORR  = 8'h04;
	localparam logic [CODE_W-1:0] CODE_UNALIGN = 8'h05;

	// Statistics counter slots.
	localparam int unsigned N_CNT      = 6;
	localparam int unsigned CNT_TOTAL  = 0;
	localparam int unsigned CNT_NOERR  = 1;
	localparam int unsigned CNT_CORR   = 2;
	localparam int unsigned CNT_UNCORR = 3;
	localparam int unsigned CNT_FAILS  = 4;
	localparam int unsigned CNT_UNLOCK = 5;

	// Operator and transceiver inputs that arrive from outside the clock.
	typedef struct packed {
		logic glob_reset;
		logic loopback;
		logic ind_en;
		logic rx_done;
		logic tx_done;
		logic stats_clear;
		logic inj_slip;
		logic inj_corr;
		logic inj_uncorr;
		logic bist_start;
	} fecth_ops_type;

	// Per-codeword outcome flags from the decoder.
	typedef struct packed {
		logic no_error;
		logic corrected;
		logic uncorrected;
	} fecth_cw_stat_type;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_ALIGN = 3'h1,
		ST_LOCK  = 3'h2,
		ST_RUN   = 3'h3,
		ST_DONE  = 3'h4
	} fecth_state_type;

endpackage

`default_nettype wire

// ---- design/fecth_in_sync.sv ----
// Two-stage synchroniser with rising-edge detect for outside inputs.
`default_nettype none

module fecth_in_sync #(
	parameter int unsigned W = 1
) (
	// Clock, reset, enable.
	input  wire logic         ref_clk,
	input  wire logic         resetn,
	input  wire logic         clk_en,
	// Raw inputs and their synchronised forms.
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else if (clk_en) begin
			meta_q <= async_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	// A held-high control yields one pulse only.
	assign rise = sync_q & ~prev_q;

endmodule

`default_nettype wire

// ---- design/fecth_stat_ctr.sv ----
// One 32-bit statistics counter with synchronous clear.
`default_nettype none

module fecth_stat_ctr
	import fecth_pkg::*;
(
	// Clock, reset, enable.
	input  wire logic             ref_clk,
	input  wire logic             resetn,
	input  wire logic             clk_en,
	// Control and count.
	input  wire logic             clear,
	input  wire logic             inc,
	output logic      [CTR_W-1:0] count
);

	logic [CTR_W-1:0] count_q;

	// Clear wins over a same-cycle increment so all slots zero together.
	always_ff @(posedge ref_clk) begin
		if (!resetn || (clk_en && clear)) begin
			count_q <= '0;
		end else if (clk_en && inc) begin
			count_q <= count_q + 1'b1;
		end
	end

	assign count = count_q;

endmodule

`default_nettype wire

// ---- design/fecth_harness.sv ----
// Self-checking harness around the codec core: test, injection, stats.
//
// What this block does
// - Pass flag goes high once the self-test ends successfully.
// - Fail flag goes high when the self-test detects a failure.
// - Running flag stays high while the self-test is in progress.
// - Eight-bit result code reads zero on success, otherwise the cause.
// - A start pulse from the operator begins the self-test.
// - Indication enable passes straight to the codec input.
// - Uncorrectable-injection pulse corrupts the stream beyond repair.
// - Correctable-injection pulse inserts one error the decoder can fix.
// - Slip-injection pulse requests one transceiver gearbox slip.
// - Counter of every codeword the decoder processes.
// - Counter of decoded codewords without errors.
// - Counter of decoded codewords with corrected errors.
// - Counter of decoded codewords with uncorrectable errors.
// - Counter of data checker mismatches.
// - Counter of alignment losses, on each falling alignment edge.
// - Statistics-clear pulse zeroes all counters at once.
// - Alignment status output follows the codec alignment flag.
// - Checker-locked flag high while the checker tracks decoded data.
// - Separate outputs report receive and transmit reset completion.
// - Global reset control high holds the harness in reset, all but its input synchroniser.
// - Decoded data is valid only once alignment is reported.
`default_nettype none

module fecth_harness
	import fecth_pkg::*;
#(
	parameter int unsigned ALIGN_LIMIT = 68000,
	parameter int unsigned BIST_WORDS  = 200000
) (
	// Clock, reset, enable.
	input  wire logic                ref_clk,
	input  wire logic                resetn,
	input  wire logic                clk_en,
	// Operator controls and transceiver status, outside the clock.
	input  wire fecth_ops_type       ops_in,
	// Self-test status.
	output logic                     bist_pass,
	output logic                     bist_fail,
	output logic                     bist_running,
	output logic        [CODE_W-1:0] bist_code,
	// Statistics.
	output logic        [CTR_W-1:0]  rx_total,
	output logic        [CTR_W-1:0]  rx_noerrors,
	output logic        [CTR_W-1:0]  rx_corrected,
	output logic        [CTR_W-1:0]  rx_uncorrected,
	output logic        [CTR_W-1:0]  rx_data_fails,
	output logic        [CTR_W-1:0]  rx_unlocks,
	// Mirrored status and checker lock.
	output logic                     align_status,
	output logic                     checker_locked,
	output logic                     transceiver_receive_reset_done,
	output logic                     transceiver_transmit_reset_done,
	// Codec transmit side.
	output logic        [WORD_W-1:0] tx_din,
	output logic                     tx_din_start,
	input  wire logic   [WORD_W-1:0] tx_enc,
	// Codec receive side.
	output logic                     indication_en,
	input  wire logic                stat_rx_aligned,
	input  wire logic   [WORD_W-1:0] rx_dout,
	input  wire fecth_cw_stat_type   cw_stat,
	// Transceiver.
	output logic        [WORD_W-1:0] gt_tx_data,
	output logic                     gt_rx_slip,
	output logic                     gt_loopback
);

	fecth_ops_type     ops_lvl;
	fecth_ops_type     ops_rise;
	logic              srst_n;
	logic [CTR_W-1:0]  counts [N_CNT];
	logic [N_CNT-1:0]  cnt_inc;
	logic              chk_fail;

	////////////////////////////////////////////////////////////////////////

	fecth_in_sync #(
		.W ($bits(fecth_ops_type))
	) u_sync (
		.ref_clk  (ref_clk),
		.resetn   (resetn),
		.clk_en   (clk_en),
		.async_in (ops_in),
		.level    (ops_lvl),
		.rise     (ops_rise)
	);

	// The synchroniser itself sits on the board reset only, so it keeps
	// tracking the global reset control while the rest is held.
	assign srst_n = resetn && !ops_lvl.glob_reset;

	////////////////////////////////////////////////////////////////////////

	logic        [WORD_W-3:0] tx_seq_q;
	logic        [WCNT_W-1:0] tx_word_q;

	// Payload is a running count, so the checker can predict each word.
	always_ff @(posedge ref_clk) begin
		if (!srst_n) begin
			tx_seq_q     <= '0;
			tx_word_q    <= '0;
			tx_din       <= '0;
			tx_din_start <= 1'b0;
		end else if (clk_en) begin
			tx_seq_q     <= tx_seq_q + 1'b1;
			tx_word_q    <= tx_word_q + 1'b1;
			tx_din       <= {tx_seq_q, SYNC_DATA};
			tx_din_start <= (tx_word_q == '0);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!srst_n) begin
			gt_tx_data <= '0;
		end else if (clk_en) begin
			if (ops_rise.inj_uncorr) begin
				gt_tx_data <= tx_enc ^ UNCORR_MASK;
			end else if (ops_rise.inj_corr) begin
				gt_tx_data <= tx_enc ^ CORR_MASK;
			end else begin
				gt_tx_data <= tx_enc;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!srst_n) begin
			gt_rx_slip <= 1'b0;
		end else if (clk_en) begin
			gt_rx_slip <= ops_rise.inj_slip;
		end
	end

	////////////////////////////////////////////////////////////////////////

	always_ff @(posedge ref_clk) begin
		if (!srst_n) begin
			indication_en                   <= 1'b0;
			gt_loopback                     <= 1'b0;
			align_status                    <= 1'b0;
			transceiver_receive_reset_done  <= 1'b0;
			transceiver_transmit_reset_done <= 1'b0;
		end else if (clk_en) begin
			indication_en                   <= ops_lvl.ind_en;
			gt_loopback                     <= ops_lvl.loopback;
			align_status                    <= stat_rx_aligned;
			transceiver_receive_reset_done  <= ops_lvl.rx_done;
			transceiver_transmit_reset_done <= ops_lvl.tx_done;
		end
	end

	////////////////////////////////////////////////////////////////////////

	logic [WORD_W-3:0] chk_prev_q;
	logic [3:0]        chk_run_q;
	logic              chk_match;

	assign chk_match = (rx_dout == {chk_prev_q + 1'b1, SYNC_DATA});
	assign chk_fail  = checker_locked && stat_rx_aligned && !chk_match;

	// Decoded words count only while the codec reports alignment.
	always_ff @(posedge ref_clk) begin
		if (!srst_n) begin
			chk_prev_q     <= '0;
			chk_run_q      <= '0;
			checker_locked <= 1'b0;
		end else if (clk_en) begin
			if (!stat_rx_aligned) begin
				chk_run_q      <= '0;
				checker_locked <= 1'b0;
			end else begin
				chk_prev_q <= rx_dout[WORD_W-1:2];
				if (chk_match) begin
					if (chk_run_q == CHK_LOCK_RUN) begin
						checker_locked <= 1'b1;
					end else begin
						chk_run_q <= chk_run_q + 1'b1;
					end
				end else begin
					chk_run_q      <= '0;
					checker_locked <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////

	logic aligned_q;

	always_ff @(posedge ref_clk) begin
		if (!srst_n) begin
			aligned_q <= 1'b0;
		end else if (clk_en) begin
			aligned_q <= stat_rx_aligned;
		end
	end

	assign cnt_inc[CNT_TOTAL]  = |cw_stat;
	assign cnt_inc[CNT_NOERR]  = cw_stat.no_error;
	assign cnt_inc[CNT_CORR]   = cw_stat.corrected;
	assign cnt_inc[CNT_UNCORR] = cw_stat.uncorrected;
	assign cnt_inc[CNT_FAILS]  = chk_fail;
	assign cnt_inc[CNT_UNLOCK] = aligned_q && !stat_rx_aligned;

	for (genvar i = 0; i < N_CNT; i++) begin : g_ctr
		fecth_stat_ctr u_ctr (
			.ref_clk (ref_clk),
			.resetn  (srst_n),
			.clk_en  (clk_en),
			.clear   (ops_rise.stats_clear),
			.inc     (cnt_inc[i]),
			.count   (counts[i])
		);
	end

	assign rx_total       = counts[CNT_TOTAL];
	assign rx_noerrors    = counts[CNT_NOERR];
	assign rx_corrected   = counts[CNT_CORR];
	assign rx_uncorrected = counts[CNT_UNCORR];
	assign rx_data_fails  = counts[CNT_FAILS];
	assign rx_unlocks     = counts[CNT_UNLOCK];

	////////////////////////////////////////////////////////////////////////

	fecth_state_type  state_q;
	logic [TMR_W-1:0] tmr_q;

	function automatic logic [TMR_W-1:0] lim(input int unsigned v);
		lim = TMR_W'(v);
	endfunction

	always_ff @(posedge ref_clk) begin
		if (!srst_n) begin
			state_q      <= ST_IDLE;
			tmr_q        <= '0;
			bist_pass    <= 1'b0;
			bist_fail    <= 1'b0;
			bist_running <= 1'b0;
			bist_code    <= CODE_OK;
		end else if (clk_en) begin
			tmr_q <= tmr_q + 1'b1;
			if (ops_rise.bist_start) begin
				state_q      <= ST_ALIGN;
				tmr_q        <= '0;
				bist_pass    <= 1'b0;
				bist_fail    <= 1'b0;
				bist_running <= 1'b1;
				bist_code    <= CODE_OK;
			end else begin
				unique case (state_q)
					ST_IDLE, ST_DONE: begin
						tmr_q <= tmr_q;
					end
					ST_ALIGN: begin
						if (stat_rx_aligned) begin
							state_q <= ST_LOCK;
							tmr_q   <= '0;
						end else if (tmr_q == lim(ALIGN_LIMIT)) begin
							state_q      <= ST_DONE;
							bist_running <= 1'b0;
							bist_fail    <= 1'b1;
							bist_code    <= CODE_ALIGN;
						end
					end
					ST_LOCK: begin
						if (checker_locked) begin
							state_q <= ST_RUN;
							tmr_q   <= '0;
						end else if (tmr_q == LOCK_LIMIT) begin
							state_q      <= ST_DONE;
							bist_running <= 1'b0;
							bist_fail    <= 1'b1;
							bist_code    <= CODE_LOCK;
						end
					end
					ST_RUN: begin
						tmr_q <= tmr_q + TMR_W'(|cw_stat);
						if (chk_fail || cw_stat.uncorrected ||
						    !stat_rx_aligned) begin
							state_q      <= ST_DONE;
							bist_running <= 1'b0;
							bist_fail    <= 1'b1;
							if (!stat_rx_aligned) begin
								bist_code <= CODE_UNALIGN;
							end else if (chk_fail) begin
								bist_code <= CODE_DATA;
							end else begin
								bist_code <= CODE_UNCORR;
							end
						end else if (tmr_q == lim(BIST_WORDS)) begin
							state_q      <= ST_DONE;
							bist_running <= 1'b0;
							bist_pass    <= 1'b1;
							bist_code    <= CODE_OK;
						end
					end
					default: begin
						state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////

	a_pass_code_zero: assert property (@(posedge ref_clk) disable iff (!srst_n)
		bist_pass |-> (bist_code == CODE_OK && !bist_fail))
		else $error("pass flag with nonzero code");

	a_fail_code_set: assert property (@(posedge ref_clk) disable iff (!srst_n)
		bist_fail |-> (bist_code != CODE_OK && !bist_running))
		else $error("fail flag without a cause code");

	a_start_runs: assert property (@(posedge ref_clk) disable iff (!srst_n)
		(clk_en && ops_rise.bist_start) |=> (bist_running && !bist_pass))
		else $error("start pulse did not begin the test");

	a_ind_follows: assert property (@(posedge ref_clk) disable iff (!srst_n)
		clk_en |=> (indication_en == $past(ops_lvl.ind_en)))
		else $error("indication enable not passed through");

	a_uncorr_two_bits: assert property (@(posedge ref_clk) disable iff (!srst_n)
		(clk_en && ops_rise.inj_uncorr) |=>
		($countones(gt_tx_data ^ $past(tx_enc)) == 2))
		else $error("uncorrectable injection wrong");

	a_corr_one_bit: assert property (@(posedge ref_clk) disable iff (!srst_n)
		(clk_en && ops_rise.inj_corr && !ops_rise.inj_uncorr) |=>
		($countones(gt_tx_data ^ $past(tx_enc)) == 1))
		else $error("correctable injection wrong");

	a_slip_single: assert property (@(posedge ref_clk) disable iff (!srst_n)
		gt_rx_slip |=> !gt_rx_slip)
		else $error("slip request longer than one cycle");

	a_total_is_sum: assert property (@(posedge ref_clk) disable iff (!srst_n)
		rx_total == CTR_W'(rx_noerrors + rx_corrected + rx_uncorrected))
		else $error("total differs from outcome sum");

	a_unlock_counts: assert property (@(posedge ref_clk) disable iff (!srst_n)
		(clk_en && aligned_q && !stat_rx_aligned && !ops_rise.stats_clear)
		|=> (rx_unlocks == CTR_W'($past(rx_unlocks) + 1'b1)))
		else $error("alignment loss not counted");

	a_clear_all: assert property (@(posedge ref_clk) disable iff (!srst_n)
		(clk_en && ops_rise.stats_clear) |=> (rx_total == '0 &&
		rx_data_fails == '0 && rx_unlocks == '0 && rx_corrected == '0 &&
		rx_noerrors == '0 && rx_uncorrected == '0))
		else $error("statistics not cleared together");

	a_align_mirror: assert property (@(posedge ref_clk) disable iff (!srst_n)
		clk_en |=> (align_status == $past(stat_rx_aligned)))
		else $error("alignment status not mirrored");

	a_lock_needs_align: assert property (@(posedge ref_clk) disable iff (!srst_n)
		(clk_en && !stat_rx_aligned) |=> !checker_locked)
		else $error("checker locked without alignment");

endmodule

`default_nettype wire

// ---- tb/fecth_codec_model.sv ----
// Behavioural model of the codec core and the transceiver in loopback.
`default_nettype none

module fecth_codec_model
	import fecth_pkg::*;
#(
	parameter int unsigned ALIGN_CYC = 100
) (
	// Clock and reset.
	input  wire logic              ref_clk,
	input  wire logic              resetn,
	// Encoder side.
	input  wire logic [WORD_W-1:0] tx_din,
	output logic      [WORD_W-1:0] tx_enc,
	// Transceiver side.
	input  wire logic [WORD_W-1:0] gt_tx_data,
	input  wire logic              gt_rx_slip,
	input  wire logic              gt_loopback,
	input  wire logic              block_align,
	// Decoder side.
	output logic                   stat_rx_aligned,
	output logic      [WORD_W-1:0] rx_dout,
	output fecth_cw_stat_type      cw_stat
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [WORD_W-1:0] sent_q;
	logic [WORD_W-1:0] fixed;
	logic [31:0]       wait_q;
	logic [4:0]        word_q;
	logic              corr_q;
	logic              bad_q;
	logic              corr_now;
	logic              bad_now;
	int unsigned       n_err;

	////////////////////////////////////////////////////////////////////////
	// Errors are found by comparing the received word with what was sent.
	always_comb begin
		n_err = $countones(gt_tx_data ^ sent_q);
		fixed = (n_err < 2) ? sent_q : gt_tx_data;
		corr_now = corr_q | (n_err == 1);
		bad_now = bad_q | (n_err > 1);
	end

	always_ff @(posedge ref_clk) begin
		tx_enc <= resetn ? tx_din : '0;
		sent_q <= resetn ? tx_enc : '0;
	end

	////////////////////////////////////////////////////////////////////////
	// Any slip or loss of the loop restarts the search from the start.
	always_ff @(posedge ref_clk) begin
		if (!resetn || gt_rx_slip || block_align || !gt_loopback) begin
			wait_q <= 32'h0;
			stat_rx_aligned <= 1'b0;
		end else if (wait_q == ALIGN_CYC) begin
			stat_rx_aligned <= 1'b1;
		end else begin
			wait_q <= wait_q + 32'h1;
		end
	end

	// Unaligned output toggles so that stale words never look valid.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			rx_dout <= '0;
		end else begin
			rx_dout <= stat_rx_aligned ? fixed : ~rx_dout;
		end
	end

	always_ff @(posedge ref_clk) begin
		cw_stat <= '0;
		if (!resetn || !stat_rx_aligned) begin
			word_q <= 5'h0;
			corr_q <= 1'b0;
			bad_q <= 1'b0;
		end else begin
			word_q <= word_q + 5'h1;
			corr_q <= (word_q == 5'h1f) ? 1'b0 : corr_now;
			bad_q <= (word_q == 5'h1f) ? 1'b0 : bad_now;
			if (word_q == 5'h1f) begin
				cw_stat <= {!(corr_now | bad_now), corr_now & !bad_now, bad_now};
			end
		end
	end
endmodule

`default_nettype wire

// ---- tb/fecth_harness_test.sv ----
// Self-checking bench of the codec test harness.
`default_nettype none

module fecth_harness_test
	import fecth_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	localparam int unsigned AL = 200;

	logic ref_clk, resetn, clk_en, block_align;
	fecth_ops_type ops_in;
	logic bist_pass, bist_fail, bist_running;
	logic [CODE_W-1:0] bist_code;
	logic [CTR_W-1:0] rx_total, rx_noerrors, rx_corrected, rx_uncorrected;
	logic [CTR_W-1:0] rx_data_fails, rx_unlocks, v0, v1;
	logic align_status, checker_locked, indication_en;
	logic transceiver_receive_reset_done, transceiver_transmit_reset_done;
	logic [WORD_W-1:0] tx_din, tx_enc, gt_tx_data, rx_dout;
	logic tx_din_start, stat_rx_aligned, gt_rx_slip, gt_loopback;
	fecth_cw_stat_type cw_stat;
	int n_fail, samples_checked, i;
	int cyc = 0;
	int slips = 0;

	fecth_harness #(.ALIGN_LIMIT(AL), .BIST_WORDS(20)) fecth_harness_inst (
		.ref_clk, .resetn, .clk_en, .ops_in, .bist_pass, .bist_fail,
		.bist_running, .bist_code, .rx_total, .rx_noerrors, .rx_corrected,
		.rx_uncorrected, .rx_data_fails, .rx_unlocks, .align_status,
		.checker_locked, .transceiver_receive_reset_done,
		.transceiver_transmit_reset_done, .tx_din, .tx_din_start, .tx_enc,
		.indication_en, .stat_rx_aligned, .rx_dout, .cw_stat, .gt_tx_data,
		.gt_rx_slip, .gt_loopback
	);

	fecth_codec_model #(.ALIGN_CYC(100)) fecth_codec_model_inst (
		.ref_clk, .resetn, .tx_din, .tx_enc, .gt_tx_data, .gt_rx_slip,
		.gt_loopback, .block_align, .stat_rx_aligned, .rx_dout, .cw_stat
	);

	////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic close_out();
		$display("checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// A hung wait ends the run with a mismatch.
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (gt_rx_slip === 1'b1) slips <= slips + 1;
		if (cyc == 20000) begin
			n_fail++;
			close_out();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic pulse(input int idx, input int len);
		ops_in[idx] = 1'b1;
		tick(len);
		ops_in[idx] = 1'b0;
		tick(2);
	endtask

	task automatic chk_bit(input logic exp, input logic got, input string m);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	task automatic chk_word(input logic [CTR_W-1:0] exp, input logic
		[CTR_W-1:0] got, input string m);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		n_fail = 0;
		samples_checked = 0;
		resetn = 1'b0;
		clk_en = 1'b1;
		block_align = 1'b1;
		ops_in = '0;
		tick(20);
		chk_word(32'h0, rx_total, "total in reset");
		chk_word({24'h0, bist_code}, 32'h0, "code in reset");
		resetn = 1'b1;
		ops_in.loopback = 1'b1;
		ops_in.rx_done = 1'b1;
		ops_in.tx_done = 1'b1;
		ops_in.ind_en = 1'b1;
		tick(5);
		chk_bit(1'b1, transceiver_receive_reset_done, "rx done");
		chk_bit(1'b1, indication_en, "indication on");
		ops_in.rx_done = 1'b0;
		ops_in.ind_en = 1'b0;
		tick(5);
		chk_bit(1'b0, transceiver_receive_reset_done, "rx done low");
		chk_bit(1'b1, transceiver_transmit_reset_done, "tx done");
		chk_bit(1'b0, indication_en, "indication off");
		pulse(0, 2);
		chk_bit(1'b1, bist_running, "running after start");
		for (i = 0; i < 2 * AL && bist_fail !== 1'b1; i++) tick(1);
		chk_bit(1'b1, bist_fail, "align timeout fail");
		chk_bit(1'b1, i > AL - 20, "timeout too early");
		chk_word({24'h0, bist_code}, {24'h0, CODE_ALIGN}, "timeout code");
		chk_bit(1'b0, bist_running, "running after fail");
		block_align = 1'b0;
		for (i = 0; i < 300 && align_status !== 1'b1; i++) tick(1);
		chk_bit(1'b1, align_status, "alignment");
		for (i = 0; i < 100 && checker_locked !== 1'b1; i++) tick(1);
		chk_bit(1'b1, checker_locked, "checker lock");
		pulse(4, 1);
		for (i = 0; i < 10 && rx_total !== 32'h0; i++) tick(1);
		chk_word(32'h0, rx_total | rx_noerrors | rx_corrected, "clear a");
		chk_word(32'h0, rx_uncorrected | rx_data_fails | rx_unlocks,
			"clear b");
		tick(256);
		chk_bit(1'b1, rx_total >= 7 && rx_total <= 9, "total rate");
		chk_word(rx_noerrors + rx_corrected + rx_uncorrected, rx_total,
			"sum");
		chk_bit(1'b1, rx_noerrors != 0, "clean words");
		v0 = rx_corrected;
		v1 = rx_data_fails;
		pulse(2, 5);
		tick(80);
		chk_word(v0 + 1, rx_corrected, "one corrected");
		chk_word(v1, rx_data_fails, "no false mismatch");
		v0 = rx_uncorrected;
		pulse(1, 5);
		tick(80);
		chk_word(v0 + 1, rx_uncorrected, "one uncorrected");
		chk_bit(1'b1, rx_data_fails != v1, "mismatch counted");
		v0 = rx_unlocks;
		v1 = slips;
		pulse(3, 4);
		tick(10);
		chk_word(v1 + 1, slips, "one slip");
		chk_bit(1'b0, align_status, "alignment lost");
		chk_word(v0 + 1, rx_unlocks, "unlock count");
		for (i = 0; i < 300 && align_status !== 1'b1; i++) tick(1);
		for (i = 0; i < 100 && checker_locked !== 1'b1; i++) tick(1);
		chk_bit(1'b1, checker_locked, "relock");
		pulse(0, 1);
		for (i = 0; i < 3000 && bist_pass !== 1'b1; i++) tick(1);
		chk_bit(1'b1, bist_pass, "test pass");
		chk_bit(1'b0, bist_fail | bist_running, "pass flags");
		chk_word({24'h0, bist_code}, 32'h0, "pass code");
		pulse(0, 1);
		tick(20);
		pulse(1, 1);
		for (i = 0; i < 300 && bist_fail !== 1'b1; i++) tick(1);
		chk_bit(1'b1, bist_fail, "injected fail");
		chk_bit(1'b0, bist_pass, "no pass on fail");
		chk_bit(1'b1, bist_code != CODE_OK, "fail code");
		ops_in.glob_reset = 1'b1;
		tick(6);
		chk_word(32'h0, rx_total, "global reset");
		chk_bit(1'b0, bist_fail | gt_loopback, "global reset flags");
		ops_in.glob_reset = 1'b0;
		tick(6);
		chk_bit(1'b1, gt_loopback, "leave reset");
		for (i = 0; i < 40 && tx_din_start !== 1'b1; i++) tick(1);
		tick(32);
		chk_bit(1'b1, tx_din_start, "codeword start period");
		chk_word({30'h0, SYNC_DATA}, {30'h0, tx_din[1:0]}, "sync");
		close_out();
	end
endmodule

`default_nettype wire
